//--- sensor_timing_end.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RL1] slave: processor drives frame/line sync per mode
// [RL2] role pin static before reset release; processor sets it on the first edge after release
// [RL3] master timing starts after run control zero
// [RL4] master frame lines and line clocks registers
// [RL5] frame sync low width 1H/2H/4H/8H
// [RL6] line sync low width doubles per code
// [RL7] output select: 0 high, 2 sync
// [RL8] syncs start at run write or standby exit
// [RL9] receiver aligns to sync codes, not syncs
// [RL10] gain code is dB times 10/3, max e6
// [RL11] gain applies from next frame
// [RL12] nine-bit black offset added after gain
// [RL13] recommended black offset 03c or 0f0
// [RL14] direction bits: vertical bit0, horizontal bit1
// [RL15] direction change between frames, one invalid
// [RL16] rolling shutter in whole lines
// [RL17] integration = frame minus (shutter+1) lines
// [RL18] slave frame lines counted; master from register
// [RL19] shutter between 1 and lines minus 2; the code does not check writes, and reset loads 0
// [RL20] integration change shows next frame
// [RL21] long exposure by lengthening the frame
// [RL22] working copies captured at frame boundary
module sensor_timing_end (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // control port and role strap
  input  wire logic        i_role_select,
  input  wire logic        i_wr_en,
  input  wire logic [15:0] i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  // sync pins, three signals each
  input  wire logic        i_frame_sync,
  input  wire logic        i_line_sync,
  output logic             o_frame_sync,
  output logic             o_frame_sync_oe,
  output logic             o_line_sync,
  output logic             o_line_sync_oe,
  // working settings toward the pixel path
  output logic [7:0]       o_gain,
  output logic [8:0]       o_black_offset,
  output logic             o_vertical_flip,
  output logic             o_horizontal_mirror,
  output logic             o_frame_invalid,
  output logic             o_frame_start,
  output logic             o_line_reset,
  output logic [17:0]      o_read_line,
  output logic [17:0]      o_reset_line,
  output logic [17:0]      o_frame_lines
);

  typedef enum logic [1:0] {ST_STANDBY, ST_WAIT_RUN, ST_RUN} mode_e;

  typedef struct packed {
    mode_e       mode;
    logic        slave;
    logic        standby;
    logic        run_n;
    logic [17:0] lines_reg, shutter_reg;
    logic [13:0] clocks_reg;
    logic [8:0]  black_reg;
    logic [7:0]  gain_reg;
    logic [1:0]  dir_reg, fs_width, ls_width, fs_sel, ls_sel;
    logic [17:0] lines_w, shutter_w;
    logic [13:0] clocks_w;
    logic [1:0]  fs_width_w, ls_width_w;
    logic [13:0] hcnt;
    logic [17:0] vcnt, slave_lines;
    logic [2:0]  fs_s, ls_s;
    logic        fs_o, ls_o, oe;
    logic [7:0]  gain_o;
    logic [8:0]  black_o;
    logic [1:0]  dir_o;
    logic        invalid, fstart, lreset;
    logic [17:0] read_line, reset_line, lines_o;
  } state_s;

  state_s q, d;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic        frame_edge, line_edge, line_end;
    logic [17:0] shut_line;
    logic [13:0] ls_low;
    frame_edge = 1'b0;
    line_edge  = 1'b0;
    line_end   = (q.hcnt + 14'h0001 >= q.clocks_w);
    shut_line  = q.shutter_w + 18'h00001;
    ls_low     = sensor_sync_pkg::LS_BASE_CLOCKS << q.ls_width_w;
    d          = q;
    d.fstart   = 1'b0;
    d.lreset   = 1'b0;
    d.fs_s     = {q.fs_s[1:0], i_frame_sync};
    d.ls_s     = {q.ls_s[1:0], i_line_sync};
    // register writes; partial words stay in holding regs
    if (i_wr_en) begin
      unique case (i_wr_addr)
        sensor_sync_pkg::ADDR_STANDBY:      d.standby = i_wr_data[0];
        sensor_sync_pkg::ADDR_DIRECTION:    d.dir_reg = i_wr_data[1:0]; // [RL14]
        sensor_sync_pkg::ADDR_BLACK_LOW:    d.black_reg[7:0] = i_wr_data;
        sensor_sync_pkg::ADDR_BLACK_HIGH:   d.black_reg[8] = i_wr_data[0];
        sensor_sync_pkg::ADDR_GAIN: begin
          if (i_wr_data <= sensor_sync_pkg::GAIN_MAX) begin
            d.gain_reg = i_wr_data; // [RL10]
          end
        end
        sensor_sync_pkg::ADDR_LINES_LOW:    d.lines_reg[7:0] = i_wr_data;
        sensor_sync_pkg::ADDR_LINES_MID:    d.lines_reg[15:8] = i_wr_data;
        sensor_sync_pkg::ADDR_LINES_HIGH:   d.lines_reg[17:16] = i_wr_data[1:0];
        sensor_sync_pkg::ADDR_CLOCKS_LOW:   d.clocks_reg[7:0] = i_wr_data;
        sensor_sync_pkg::ADDR_CLOCKS_HIGH:  d.clocks_reg[13:8] = i_wr_data[5:0];
        sensor_sync_pkg::ADDR_SHUTTER_LOW:  d.shutter_reg[7:0] = i_wr_data;
        sensor_sync_pkg::ADDR_SHUTTER_MID:  d.shutter_reg[15:8] = i_wr_data;
        sensor_sync_pkg::ADDR_SHUTTER_HIGH: d.shutter_reg[17:16] = i_wr_data[1:0];
        sensor_sync_pkg::ADDR_FS_WIDTH:     d.fs_width = i_wr_data[5:4];
        sensor_sync_pkg::ADDR_LS_WIDTH:     d.ls_width = i_wr_data[5:4];
        sensor_sync_pkg::ADDR_SYNC_SELECT: begin
          d.fs_sel = i_wr_data[1:0];
          d.ls_sel = i_wr_data[3:2];
        end
        sensor_sync_pkg::ADDR_MASTER_RUN:   d.run_n = i_wr_data[0];
        default: ;
      endcase
    end
    // strap sampled after release; pin must not move afterwards [RL2]
    unique case (q.mode)
      ST_STANDBY: begin
        d.slave = i_role_select;
        d.hcnt  = '0;
        d.vcnt  = '0;
        if (!q.standby) begin
          d.mode = ST_WAIT_RUN;
        end
      end
      ST_WAIT_RUN: begin
        // master waits for run control zero; written early it starts now [RL3] [RL8]
        if (q.standby) begin
          d.mode = ST_STANDBY;
        end else if (q.slave || !q.run_n) begin
          d.mode = ST_RUN;
          frame_edge = !q.slave;
        end
      end
      ST_RUN: begin
        if (q.standby || (!q.slave && q.run_n)) begin
          d.mode = ST_STANDBY;
        end else if (q.slave) begin
          // slave follows falling edges of the synced pins [RL1]
          line_edge  = q.ls_s[2] && !q.ls_s[1];
          frame_edge = q.fs_s[2] && !q.fs_s[1];
        end else begin
          // master counts clocks per line, lines per frame [RL4]
          d.hcnt = line_end ? 14'h0000 : q.hcnt + 14'h0001;
          line_edge  = line_end;
          frame_edge = line_end && (q.vcnt + 18'h00001 >= q.lines_w);
        end
      end
      default: d.mode = ST_STANDBY;
    endcase
    if (line_edge) begin
      d.vcnt = q.vcnt + 18'h00001;
    end
    // frame boundary: take working copies [RL22] [RL11] [RL20] [RL15]
    if (frame_edge) begin
      d.slave_lines = q.vcnt + 18'h00001;   // [RL18]
      d.lines_w    = q.lines_reg;          // [RL21]
      d.clocks_w   = q.clocks_reg;
      d.shutter_w  = q.shutter_reg;
      d.fs_width_w = q.fs_width;
      d.ls_width_w = q.ls_width;
      d.gain_o     = q.gain_reg;
      d.black_o    = q.black_reg;          // [RL12]
      d.invalid    = (q.dir_reg != q.dir_o);
      d.dir_o      = q.dir_reg;
      d.vcnt       = '0;
      d.hcnt       = '0;
      d.fstart     = 1'b1;
    end
    d.lines_o = q.slave ? q.slave_lines : q.lines_w;
    // rolling shutter: reset line leads readout by lines-(shutter+1) [RL16] [RL17]
    d.read_line  = q.vcnt;
    d.reset_line = (q.vcnt >= shut_line) ? q.vcnt - shut_line
                                         : q.vcnt + d.lines_o - shut_line;
    d.lreset     = line_edge;
    // generated syncs low for 1H..8H and for the line width code [RL5] [RL6]
    // code 2 passes the pulse, any other code holds the pin high [RL7]
    d.fs_o = !(q.fs_sel == sensor_sync_pkg::SEL_SYNC && q.mode == ST_RUN && !q.slave
               && q.vcnt < (18'h00001 << q.fs_width_w));
    d.ls_o = !(q.ls_sel == sensor_sync_pkg::SEL_SYNC && q.mode == ST_RUN && !q.slave
               && q.hcnt < ls_low);
    // enables registered too, so every pin leaves a flip-flop
    d.oe   = !d.slave && d.mode != ST_STANDBY;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      q             <= '0;
      q.mode        <= ST_STANDBY;
      q.standby     <= 1'b1;
      q.run_n       <= 1'b1;
      q.lines_reg   <= sensor_sync_pkg::RST_FRAME_LINES;
      q.lines_w     <= sensor_sync_pkg::RST_FRAME_LINES;
      q.clocks_reg  <= sensor_sync_pkg::RST_LINE_CLOCKS;
      q.clocks_w    <= sensor_sync_pkg::RST_LINE_CLOCKS;
      q.shutter_reg <= sensor_sync_pkg::RST_SHUTTER;
      q.black_reg   <= sensor_sync_pkg::RST_BLACK;
      q.black_o     <= sensor_sync_pkg::RST_BLACK;
      q.gain_reg    <= sensor_sync_pkg::RST_GAIN;
      q.fs_s        <= 3'h7;
      q.ls_s        <= 3'h7;
      q.fs_o        <= 1'b1;
      q.ls_o        <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign o_frame_sync        = q.fs_o;
  assign o_line_sync         = q.ls_o;
  assign o_frame_sync_oe     = q.oe;
  assign o_line_sync_oe      = q.oe;
  assign o_gain              = q.gain_o;
  assign o_black_offset      = q.black_o;
  assign o_vertical_flip     = q.dir_o[sensor_sync_pkg::POS_VFLIP];
  assign o_horizontal_mirror = q.dir_o[sensor_sync_pkg::POS_HMIRROR];
  assign o_frame_invalid     = q.invalid;
  assign o_frame_start       = q.fstart;
  assign o_line_reset        = q.lreset;
  assign o_read_line         = q.read_line;
  assign o_reset_line        = q.reset_line;
  assign o_frame_lines       = q.lines_o;

endmodule : sensor_timing_end
`default_nettype wire

//--- sensor_sync_pkg.sv
package sensor_sync_pkg;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] ADDR_STANDBY        = 16'h3000;
  localparam logic [15:0] ADDR_DIRECTION      = 16'h3007;
  localparam logic [15:0] ADDR_BLACK_LOW      = 16'h300a;
  localparam logic [15:0] ADDR_BLACK_HIGH     = 16'h300b;
  localparam logic [15:0] ADDR_GAIN           = 16'h3014;
  localparam logic [15:0] ADDR_LINES_LOW      = 16'h3018;
  localparam logic [15:0] ADDR_LINES_MID      = 16'h3019;
  localparam logic [15:0] ADDR_LINES_HIGH     = 16'h301a;
  localparam logic [15:0] ADDR_CLOCKS_LOW     = 16'h301c;
  localparam logic [15:0] ADDR_CLOCKS_HIGH    = 16'h301d;
  localparam logic [15:0] ADDR_SHUTTER_LOW    = 16'h3020;
  localparam logic [15:0] ADDR_SHUTTER_MID    = 16'h3021;
  localparam logic [15:0] ADDR_SHUTTER_HIGH   = 16'h3022;
  localparam logic [15:0] ADDR_FS_WIDTH       = 16'h3048;
  localparam logic [15:0] ADDR_LS_WIDTH       = 16'h3049;
  localparam logic [15:0] ADDR_SYNC_SELECT    = 16'h304b;
  localparam logic [15:0] ADDR_MASTER_RUN     = 16'h304c;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int POS_VFLIP      = 0;
  localparam int POS_HMIRROR    = 1;
  localparam int POS_WIDTH_LSB  = 4;
  localparam int POS_FS_SEL_LSB = 0;
  localparam int POS_LS_SEL_LSB = 2;

  // ------------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------------
  localparam logic [17:0] RST_FRAME_LINES = 18'h00465;
  localparam logic [13:0] RST_LINE_CLOCKS = 14'h0898;
  localparam logic [17:0] RST_SHUTTER     = 18'h00000;
  localparam logic [8:0]  RST_BLACK       = 9'h0f0;
  localparam logic [7:0]  RST_GAIN        = 8'h00;
  localparam logic [7:0]  GAIN_MAX        = 8'he6;
  localparam logic [1:0]  SEL_HIGH        = 2'h0;
  localparam logic [1:0]  SEL_SYNC        = 2'h2;

  // line sync base low width, clocks for code 0 (64 output bits)
  localparam logic [13:0] LS_BASE_CLOCKS  = 14'h0008;

endpackage : sensor_sync_pkg

//--- sensor_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  logic frame_sync_pin;     // driven by the timing master
  logic line_sync_pin;
  logic role_select_pin;    // low = master, high = slave
  logic wr_en;              // control port write strobe
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;

  // both ends read the resolved pin level; drivers meet outside
  modport sensor_end (
    input  role_select_pin, wr_en, wr_addr, wr_data,
    input  frame_sync_pin, line_sync_pin
  );
  modport processor_end (
    output role_select_pin, wr_en, wr_addr, wr_data,
    input  frame_sync_pin, line_sync_pin
  );
endinterface : sensor_link_if
`default_nettype wire

//--- processor_sync_end.sv
`timescale 1ns/1ps
`default_nettype none
module processor_sync_end #(
  parameter int LINE_CLOCKS = 2200,
  parameter int FRAME_LINES = 1125
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // user side
  input  wire logic        i_slave_role,
  input  wire logic        i_sync_enable,
  input  wire logic        i_wr_req,
  input  wire logic [15:0] i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  // link side
  output logic             o_role_select,
  output logic             o_wr_en,
  output logic [15:0]      o_wr_addr,
  output logic [7:0]       o_wr_data,
  output logic             o_frame_sync,
  output logic             o_frame_sync_oe,
  output logic             o_line_sync,
  output logic             o_line_sync_oe
);

  // line sync stays low for 8 clocks, so a line needs room to go high
  if (LINE_CLOCKS < 9 || FRAME_LINES < 4) begin : g_bad_counts
    $error("sync counts too small");
  end

  typedef struct packed {
    logic        role;
    logic        armed;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [31:0] hcnt, vcnt;
    logic        fs, ls, drive;
  } state_s;

  state_s q, d;

  // ------------------------------------------------------------------
  // slave-mode sync generator, alignment left to sync codes [RL1] [RL9]
  // ------------------------------------------------------------------
  always_comb begin
    d       = q;
    d.armed = 1'b0;
    d.role  = q.armed ? i_slave_role : q.role; // [RL2]
    d.wr    = i_wr_req;
    d.addr  = i_wr_addr;
    d.data  = i_wr_data;
    d.drive = q.role && i_sync_enable;
    // counters hold at zero on the first driven cycle: full first line
    if (q.drive) begin
      d.hcnt = (q.hcnt >= LINE_CLOCKS - 1) ? 32'd0 : q.hcnt + 32'd1;
      if (q.hcnt >= LINE_CLOCKS - 1) begin
        d.vcnt = (q.vcnt >= FRAME_LINES - 1) ? 32'd0 : q.vcnt + 32'd1;
      end
    end
    d.ls = !(d.drive && d.hcnt < 32'd8);
    d.fs = !(d.drive && d.vcnt == 32'd0);
  end

  // role latched on the first edge after reset release only
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      q       <= '0;
      q.fs    <= 1'b1;
      q.ls    <= 1'b1;
      q.armed <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_role_select   = q.role;
  assign o_wr_en         = q.wr;
  assign o_wr_addr       = q.addr;
  assign o_wr_data       = q.data;
  assign o_frame_sync    = q.fs;
  assign o_line_sync     = q.ls;
  assign o_frame_sync_oe = q.drive;
  assign o_line_sync_oe  = q.drive;

endmodule : processor_sync_end
`default_nettype wire

//--- sensor_sync_props.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_sync_props #(
  parameter int LINE_CLOCKS = 20,
  parameter int FRAME_LINES = 10
) (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  // link signals
  input wire logic        frame_sync_pin,
  input wire logic        line_sync_pin,
  input wire logic        role_select_pin,
  input wire logic        wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0]  wr_data
);
  // ------------------------------------------------------------------
  // write snoop and pin counters
  // ------------------------------------------------------------------
  logic [1:0]  up_q, fsw_q, lsw_q, fsa_q, lsa_q;
  logic        stby_q, run_q, fp_q, lp_q, fseen_q, lseen_q;
  logic [3:0]  sel_q;
  logic [13:0] clk_q;
  logic [17:0] lin_q;
  logic [11:0] age_q;
  int          lof_q, lol_q, perf_q, perl_q;
  wire master = !role_select_pin && up_q == 2'h3;
  wire slave  = role_select_pin && up_q == 2'h3;
  wire go     = run_q && !stby_q;
  wire fl_f   = fp_q && !frame_sync_pin;
  wire fl_l   = lp_q && !line_sync_pin;
  wire rs_f   = !fp_q && frame_sync_pin;
  wire rs_l   = !lp_q && line_sync_pin;
  // widths latched at the frame fall, as the sensor takes them per frame
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      up_q <= 2'h0;
      stby_q <= 1'b1;
      run_q <= 1'b0;
      sel_q <= 4'h0;
      fsw_q <= 2'h0;
      lsw_q <= 2'h0;
      clk_q <= sensor_sync_pkg::RST_LINE_CLOCKS;
      lin_q <= sensor_sync_pkg::RST_FRAME_LINES;
      fp_q <= 1'b1;
      lp_q <= 1'b1;
      fseen_q <= 1'b0;
      lseen_q <= 1'b0;
      age_q <= 12'h000;
    end else begin
      up_q <= up_q + 2'(up_q != 2'h3);
      fp_q <= frame_sync_pin;
      lp_q <= line_sync_pin;
      fseen_q <= fseen_q | fl_f;
      lseen_q <= lseen_q | fl_l;
      age_q <= age_q + 12'(age_q != 12'hfff);
      if (fl_f) begin
        fsa_q <= fsw_q;
        lsa_q <= lsw_q;
      end
      if (wr_en) begin
        case (wr_addr)
          sensor_sync_pkg::ADDR_STANDBY:     stby_q <= wr_data[0];
          sensor_sync_pkg::ADDR_MASTER_RUN:  run_q <= !wr_data[0];
          sensor_sync_pkg::ADDR_CLOCKS_LOW:  clk_q[7:0] <= wr_data;
          sensor_sync_pkg::ADDR_CLOCKS_HIGH: clk_q[13:8] <= wr_data[5:0];
          sensor_sync_pkg::ADDR_LINES_LOW:   lin_q[7:0] <= wr_data;
          sensor_sync_pkg::ADDR_LINES_MID:   lin_q[15:8] <= wr_data;
          sensor_sync_pkg::ADDR_LINES_HIGH:  lin_q[17:16] <= wr_data[1:0];
          sensor_sync_pkg::ADDR_FS_WIDTH:    fsw_q <= wr_data[5:4];
          sensor_sync_pkg::ADDR_LS_WIDTH:    lsw_q <= wr_data[5:4];
          sensor_sync_pkg::ADDR_SYNC_SELECT: begin
            sel_q <= wr_data[3:0];
            age_q <= 12'h000;
          end
          default: ;
        endcase
      end
    end
    lof_q <= frame_sync_pin ? 0 : lof_q + 1;
    lol_q <= line_sync_pin ? 0 : lol_q + 1;
    perf_q <= fl_f ? 1 : perf_q + 1;
    perl_q <= fl_l ? 1 : perl_q + 1;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_role_static: assert property (up_q == 2'h3 |-> $stable(role_select_pin))
    else $error("role select moved during operation");
  a_idle_high: assert property (master && !go |-> frame_sync_pin && line_sync_pin)
    else $error("sync pulse before master start");
  a_start_bound: assert property (master && $rose(go) |-> ##[1:16] !frame_sync_pin)
    else $error("frame sync late after start");
  a_line_period: assert property (master && fl_l && lseen_q |-> perl_q == int'(clk_q))
    else $error("master line period wrong");
  a_frame_period: assert property (master && fl_f && fseen_q |->
    perf_q == int'(lin_q) * int'(clk_q))
    else $error("master frame period wrong");
  a_fs_width: assert property (master && rs_f |-> lof_q == int'(clk_q) << fsa_q)
    else $error("frame sync low width wrong");
  a_ls_width: assert property (master && rs_l |->
    lol_q == int'(sensor_sync_pkg::LS_BASE_CLOCKS) << lsa_q)
    else $error("line sync low width wrong");
  a_select_high: assert property (master && sel_q == 4'h0 && age_q == 12'hfff |->
    frame_sync_pin && line_sync_pin)
    else $error("sync pin not held high");
  a_slave_line: assert property (slave && fl_l && lseen_q |-> perl_q == LINE_CLOCKS)
    else $error("slave line period wrong");
  a_slave_frame: assert property (slave && fl_f && fseen_q |->
    perf_q == LINE_CLOCKS * FRAME_LINES)
    else $error("slave frame period wrong");
  c_start: cover property (master && $rose(go));
  c_long_fs: cover property (master && rs_f && fsa_q == 2'h3);
  c_slave: cover property (slave && fl_f && fseen_q);
  c_sel_off: cover property (master && sel_q == 4'h0 && age_q == 12'hfff);
endmodule : sensor_sync_props
`default_nettype wire

//--- tb_sensor_sync_exposure_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_sync_exposure_control;
  localparam int LC = 20;
  localparam int FL = 10;
  logic clock = 1'b0;
  logic rst, role, sen, req, p_fs, p_fs_oe, p_ls, p_ls_oe;
  logic s_fs, s_fs_oe, s_ls, s_ls_oe, vflip, hmir, finv, fstart, lres;
  logic [15:0] addr;
  logic [7:0]  data, gain;
  logic [8:0]  blk;
  logic [17:0] flines, rdl, rsl;
  int          fail_count = 0, checks = 0, cyc = 0, n, m;
  sensor_link_if sensor_link_if_i ();
  // pins pulled high when nobody drives them
  assign sensor_link_if_i.frame_sync_pin = s_fs_oe ? s_fs : (p_fs_oe ? p_fs : 1'b1);
  assign sensor_link_if_i.line_sync_pin = s_ls_oe ? s_ls : (p_ls_oe ? p_ls : 1'b1);
  processor_sync_end #(.LINE_CLOCKS(LC), .FRAME_LINES(FL)) processor_sync_end_i (
    .i_clock(clock), .i_sys_rst(rst), .i_slave_role(role), .i_sync_enable(sen),
    .i_wr_req(req), .i_wr_addr(addr), .i_wr_data(data),
    .o_role_select(sensor_link_if_i.role_select_pin), .o_wr_en(sensor_link_if_i.wr_en),
    .o_wr_addr(sensor_link_if_i.wr_addr), .o_wr_data(sensor_link_if_i.wr_data),
    .o_frame_sync(p_fs), .o_frame_sync_oe(p_fs_oe), .o_line_sync(p_ls),
    .o_line_sync_oe(p_ls_oe));
  sensor_timing_end sensor_timing_end_i (
    .i_clock(clock), .i_sys_rst(rst), .i_role_select(sensor_link_if_i.role_select_pin),
    .i_wr_en(sensor_link_if_i.wr_en), .i_wr_addr(sensor_link_if_i.wr_addr),
    .i_wr_data(sensor_link_if_i.wr_data), .i_frame_sync(sensor_link_if_i.frame_sync_pin),
    .i_line_sync(sensor_link_if_i.line_sync_pin), .o_frame_sync(s_fs),
    .o_frame_sync_oe(s_fs_oe), .o_line_sync(s_ls), .o_line_sync_oe(s_ls_oe),
    .o_gain(gain), .o_black_offset(blk), .o_vertical_flip(vflip),
    .o_horizontal_mirror(hmir), .o_frame_invalid(finv), .o_frame_start(fstart),
    .o_line_reset(lres), .o_read_line(rdl), .o_reset_line(rsl), .o_frame_lines(flines));
  sensor_sync_props #(.LINE_CLOCKS(LC), .FRAME_LINES(FL)) props_i (
    .i_clock(clock), .i_sys_rst(rst),
    .frame_sync_pin(sensor_link_if_i.frame_sync_pin),
    .line_sync_pin(sensor_link_if_i.line_sync_pin),
    .role_select_pin(sensor_link_if_i.role_select_pin), .wr_en(sensor_link_if_i.wr_en),
    .wr_addr(sensor_link_if_i.wr_addr), .wr_data(sensor_link_if_i.wr_data));

  // ------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------------------------
  always #5 clock = ~clock;
  // hang guard, well above the roughly 22k cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= 1'b1;
    addr <= a;
    data <= d;
    @(posedge clock);
    req <= 1'b0;
    // return off the edge so callers never sample a launching edge
    @(negedge clock);
  endtask : wr
  // outputs are sampled on the falling edge, away from launching edges
  task automatic next_frame;
    do @(negedge clock); while (fstart !== 1'b1);
  endtask : next_frame
  task automatic settle;
    next_frame;
    repeat (2) @(negedge clock);
  endtask : settle
  task automatic wrap_up;
    $display("checks %0d, errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------------
  // main sequence: master first, then slave after a second reset
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    role = 1'b0;
    sen = 1'b0;
    req = 1'b0;
    addr = 16'h0000;
    data = 8'h00;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // 80 clocks a line, 12 lines a frame, both pins on sync output
    wr(sensor_sync_pkg::ADDR_CLOCKS_LOW, 8'h50);
    wr(sensor_sync_pkg::ADDR_CLOCKS_HIGH, 8'h00);
    wr(sensor_sync_pkg::ADDR_LINES_LOW, 8'h0c);
    wr(sensor_sync_pkg::ADDR_LINES_MID, 8'h00);
    wr(sensor_sync_pkg::ADDR_LINES_HIGH, 8'h00);
    wr(sensor_sync_pkg::ADDR_SYNC_SELECT, 8'h0a);
    wr(sensor_sync_pkg::ADDR_SHUTTER_LOW, 8'h03);
    repeat (300) @(negedge clock);
    chk(s_fs_oe, 1'b0);
    // run written while still in standby: nothing moves yet
    wr(sensor_sync_pkg::ADDR_MASTER_RUN, 8'h00);
    repeat (100) @(negedge clock);
    chk(sensor_link_if_i.frame_sync_pin, 1'b1);
    wr(sensor_sync_pkg::ADDR_STANDBY, 8'h00);
    repeat (2) next_frame;
    n = 0;
    m = 0;
    do begin
      @(negedge clock);
      n++;
      m += int'(lres);
    end while (fstart !== 1'b1);
    chk(18'(n), 18'd960);
    chk(18'(m), 18'd12);
    chk(flines, 18'd12);
    wr(sensor_sync_pkg::ADDR_GAIN, 8'h14);
    chk(gain, 8'h00);
    settle;
    chk(gain, 8'h14);
    // line 0 read, reset four lines behind, wrapped over 12 lines
    chk(rdl, 18'd0);
    chk(rsl, 18'd8);
    // above the top code: refused, old gain kept
    wr(sensor_sync_pkg::ADDR_GAIN, 8'he7);
    settle;
    chk(gain, 8'h14);
    wr(sensor_sync_pkg::ADDR_GAIN, 8'he6);
    settle;
    chk(gain, 8'he6);
    wr(sensor_sync_pkg::ADDR_BLACK_LOW, 8'h3c);
    wr(sensor_sync_pkg::ADDR_BLACK_HIGH, 8'h01);
    chk(blk, 9'h0f0);
    settle;
    chk(blk, 9'h13c);
    wr(sensor_sync_pkg::ADDR_BLACK_HIGH, 8'h00);
    wr(sensor_sync_pkg::ADDR_DIRECTION, 8'h01);
    chk(vflip, 1'b0);
    settle;
    chk({vflip, hmir, finv}, 3'b101);
    chk(blk, 9'h03c);
    settle;
    chk(finv, 1'b0);
    // every width code, widest first; the checker measures the pulses
    for (int c = 3; c >= 0; c--) begin
      wr(sensor_sync_pkg::ADDR_FS_WIDTH, 8'(c << 4));
      wr(sensor_sync_pkg::ADDR_LS_WIDTH, 8'(c << 4));
      repeat (2) next_frame;
    end
    // select changed while both pins are high, so no pulse is cut short
    next_frame;
    repeat (200) @(negedge clock);
    wr(sensor_sync_pkg::ADDR_SYNC_SELECT, 8'h00);
    repeat (3200) @(negedge clock);
    n = 0;
    repeat (1000) begin
      @(negedge clock);
      n += int'(!sensor_link_if_i.frame_sync_pin || !sensor_link_if_i.line_sync_pin);
    end
    chk(18'(n), 18'd0);
    @(posedge clock);
    rst <= 1'b1;
    role <= 1'b1;
    sen <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wr(sensor_sync_pkg::ADDR_STANDBY, 8'h00);
    repeat (3) next_frame;
    chk(flines, 18'(FL));
    chk({sensor_link_if_i.role_select_pin, s_fs_oe}, 2'b10);
    wrap_up;
  end
endmodule : tb_sensor_sync_exposure_control
`default_nettype wire
